//--- oss_regs.vh
// oss_regs.vh: constants for the oxygen sensor serial slave and status logic
// assumes inclusion by bare name from the design files
//
// Functional notes
// - after power-on: initialise then warm up; ready low, analog level at 0% point
// - once sensor ready: ready high, analog level follows measured oxygen linearly
// - standby low forces 0% analog level, ready low and heater off
// - serial slave in clock mode 0, transactions framed by host chip select
// - each byte shifts most significant bit first on both data lines
// - fault code returned while host shifts in the first byte
// - first byte: top bit one is write, zero read; low seven bits select word
// - word 0 command read/write, word 1 signed oxygen, word 2 unsigned air ratio
// - device ignores second and third bytes of a read
// - command high byte reserved, read-only, reads zero
// - writing command low byte launches task; reading returns its status
// - command bit 5 set when last air calibration failed
// - writing one to bit 3 saves calibration; cleared when saving finishes
// - bit 0 starts air calibration; cleared on completion, failure sets bit 5
// - heater open 0x14, shorted 0x15, low energy 0x52: readings invalid
// - low supply 0x31, high supply 0x32 warnings: readings stay valid
// - normal 0x00 valid, init 0x01, warm-up/failure 0x41/0x51 invalid
// - invalid readings answer air ratio 0x0000 and oxygen 0x8000
// - read: selector then two fillers; reply fault code, low byte, high byte
`ifndef OSS_REGS_VH
`define OSS_REGS_VH

`define OSS_WORD_CMD      7'h00
`define OSS_WORD_OXY      7'h01
`define OSS_WORD_AIR      7'h02
`define OSS_WRITE_BIT     7
`define OSS_BIT_RUN_CAL   0
`define OSS_BIT_SAVE_CAL  3
`define OSS_BIT_CAL_FAIL  5
`define OSS_CMD_RESET     16'h0000

`define OSS_FC_NORMAL     8'h00
`define OSS_FC_INIT       8'h01
`define OSS_FC_HTR_OPEN   8'h14
`define OSS_FC_HTR_SHORT  8'h15
`define OSS_FC_VLOW       8'h31
`define OSS_FC_VHIGH      8'h32
`define OSS_FC_WARMUP     8'h41
`define OSS_FC_SNS_FAIL   8'h51
`define OSS_FC_NO_ENERGY  8'h52

`define OSS_OXY_INVALID   16'h8000
`define OSS_AIR_INVALID   16'h0000
`define OSS_LEVEL_ZERO    16'h0000
`define OSS_BYTE_SEL      2'd0
`define OSS_BYTE_LOW      2'd1
`define OSS_BYTE_HIGH     2'd2

`endif

//--- oss_sync.v
// oss_sync.v: two-flop synchroniser for pin inputs
// assumes the input is asynchronous to clock
`timescale 1ns/1ps
module oss_sync #(
	parameter RST_VAL = 1'b0
) (
	input  wire clock,
	input  wire reset,
	input  wire clk_en,
	input  wire d,
	output reg  q
);
	reg meta_q;

	always @(posedge clock) begin
		if (reset) begin
			meta_q <= RST_VAL;
			q      <= RST_VAL;
		end else if (clk_en) begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule // oss_sync

//--- oss_shifter.v
// oss_shifter.v: mode 0 byte shifter for the serial slave, msb first
// assumes synchronised clock and chip select levels from the same domain
`timescale 1ns/1ps
`include "oss_regs.vh"
module oss_shifter (
	input  wire       clock,
	input  wire       reset,
	input  wire       clk_en,
	input  wire       sclk_s,
	input  wire       cs_n_s,
	input  wire       mosi_s,
	input  wire [7:0] tx_byte,
	output wire       load_pulse,
	output reg        byte_done,
	output reg  [7:0] rx_byte,
	output reg        miso_q
);
	reg       sclk_q;
	reg [2:0] bit_q;
	reg [7:0] sh_q;
	reg [7:0] rxs_q;
	reg       cs_n_q;
	reg       done_q;
	wire      rise = sclk_s & ~sclk_q;
	wire      fall = ~sclk_s & sclk_q;

	// load at frame start, and one cycle after a finished byte so the
	// owner has already moved on to the next byte to send
	assign load_pulse = (cs_n_q & ~cs_n_s) | done_q;

	always @(posedge clock) begin
		if (reset) begin
			sclk_q    <= 1'b0;
			cs_n_q    <= 1'b1;
			bit_q     <= 3'd0;
			sh_q      <= 8'h00;
			rxs_q     <= 8'h00;
			rx_byte   <= 8'h00;
			byte_done <= 1'b0;
			done_q    <= 1'b0;
			miso_q    <= 1'b0;
		end else if (clk_en) begin
			sclk_q    <= sclk_s;
			cs_n_q    <= cs_n_s;
			byte_done <= 1'b0;
			done_q    <= byte_done;
			if (cs_n_s) begin
				bit_q <= 3'd0;
			end else if (rise) begin
				rxs_q <= {rxs_q[6:0], mosi_s};
				bit_q <= bit_q + 3'd1;
				if (bit_q == 3'd7) begin
					rx_byte   <= {rxs_q[6:0], mosi_s};
					byte_done <= 1'b1;
				end
			end else if (fall && bit_q != 3'd0) begin
				miso_q <= sh_q[7];
				sh_q   <= {sh_q[6:0], 1'b0};
			end
			if (load_pulse) begin
				// first bit must be on the line before the first rising edge
				miso_q <= tx_byte[7];
				sh_q   <= {tx_byte[6:0], 1'b0};
			end
		end
	end
endmodule // oss_shifter

//--- oss_slave.v
// oss_slave.v: serial slave, command word and status outputs of the oxygen sensor controller
// assumes sensor logic supplies fault code, readings and task completion strobes
`timescale 1ns/1ps
`include "oss_regs.vh"
module oss_slave (
	input  wire        clock,
	input  wire        reset,
	input  wire        clk_en,
	input  wire        sclk,
	input  wire        cs_n,
	input  wire        mosi,
	output wire        miso,
	output wire        miso_oe_n,
	input  wire        standby_n,
	input  wire [7:0]  fault_code,
	input  wire        sensor_ready,
	input  wire [15:0] oxygen_value,
	input  wire [15:0] air_ratio_value,
	input  wire [15:0] oxygen_level,
	input  wire        cal_done,
	input  wire        cal_ok,
	input  wire        save_done,
	output reg         ready_out,
	output reg  [15:0] analog_level_out,
	output reg         heater_en,
	output wire        run_cal_bit,
	output wire        save_cal_bit
);
	////////////////////////////////////////////////////////////////////
	// pin synchronisers
	wire sclk_s;
	wire cs_n_s;
	wire mosi_s;
	wire stby_n_s;

	oss_sync #(.RST_VAL(1'b0)) u_sclk (
		.clock (clock),
		.reset (reset),
		.clk_en(clk_en),
		.d     (sclk),
		.q     (sclk_s)
	);
	oss_sync #(.RST_VAL(1'b1)) u_cs (
		.clock (clock),
		.reset (reset),
		.clk_en(clk_en),
		.d     (cs_n),
		.q     (cs_n_s)
	);
	oss_sync #(.RST_VAL(1'b0)) u_mosi (
		.clock (clock),
		.reset (reset),
		.clk_en(clk_en),
		.d     (mosi),
		.q     (mosi_s)
	);
	oss_sync #(.RST_VAL(1'b1)) u_stby (
		.clock (clock),
		.reset (reset),
		.clk_en(clk_en),
		.d     (standby_n),
		.q     (stby_n_s)
	);

	////////////////////////////////////////////////////////////////////
	// reading validity and word selection
	function valid_fc;
		input [7:0] fc;
		begin
			case (fc)
				`OSS_FC_NORMAL, `OSS_FC_VLOW, `OSS_FC_VHIGH: valid_fc = 1'b1;
				default: valid_fc = 1'b0;
			endcase
		end
	endfunction

	// one-hot byte position within a frame
	localparam [2:0] ST_SEL  = 3'b001;
	localparam [2:0] ST_LOW  = 3'b010;
	localparam [2:0] ST_HIGH = 3'b100;

	reg  [15:0] cmd_q;
	reg  [2:0]  state_q;
	reg  [2:0]  state_d;
	reg         wr_q;
	reg  [6:0]  sel_q;
	reg  [15:0] word_q;
	reg  [15:0] word_d;
	wire        rd_valid = valid_fc(fault_code) & stby_n_s;
	wire        byte_done;
	wire [7:0]  rx_byte;
	wire [6:0]  sel_now = rx_byte[6:0];
	wire        wr_low;
	wire        wr_run;
	wire        wr_save;

	always @* begin
		case (sel_now)
			`OSS_WORD_CMD: word_d = {8'h00, cmd_q[7:0]};
			`OSS_WORD_OXY: word_d = rd_valid ? oxygen_value : `OSS_OXY_INVALID;
			`OSS_WORD_AIR: word_d = rd_valid ? air_ratio_value : `OSS_AIR_INVALID;
			default:       word_d = 16'h0000;
		endcase
	end

	// byte to shift out: fault code first, then low, then high
	reg [7:0] tx_byte;
	always @* begin
		case (state_q)
			ST_SEL:  tx_byte = fault_code;
			ST_LOW:  tx_byte = word_q[7:0];
			ST_HIGH: tx_byte = word_q[15:8];
			default: tx_byte = fault_code;
		endcase
	end

	oss_shifter u_shift (
		.clock     (clock),
		.reset     (reset),
		.clk_en    (clk_en),
		.sclk_s    (sclk_s),
		.cs_n_s    (cs_n_s),
		.mosi_s    (mosi_s),
		.tx_byte   (tx_byte),
		.load_pulse(),
		.byte_done (byte_done),
		.rx_byte   (rx_byte),
		.miso_q    (miso)
	);

	assign miso_oe_n = cs_n_s;

	////////////////////////////////////////////////////////////////////
	// transaction sequencing and command word
	// only byte 1 of a write to the command word reaches the command bits
	assign wr_low  = byte_done && state_q == ST_LOW && wr_q && sel_q == `OSS_WORD_CMD;
	assign wr_run  = wr_low && rx_byte[`OSS_BIT_RUN_CAL];
	assign wr_save = wr_low && rx_byte[`OSS_BIT_SAVE_CAL];

	always @* begin
		state_d = state_q;
		case (state_q)
			ST_SEL: begin
				if (byte_done)
					state_d = ST_LOW;
			end
			ST_LOW: begin
				if (byte_done)
					state_d = ST_HIGH;
			end
			ST_HIGH: begin
				if (byte_done)
					state_d = ST_SEL;
			end
			default: state_d = ST_SEL;
		endcase
		if (cs_n_s)
			state_d = ST_SEL;
	end

	always @(posedge clock) begin
		if (reset) begin
			state_q <= ST_SEL;
			wr_q    <= 1'b0;
			sel_q   <= 7'h00;
			word_q  <= 16'h0000;
		end else if (clk_en) begin
			state_q <= state_d;
			if (byte_done && state_q == ST_SEL && !cs_n_s) begin
				wr_q   <= rx_byte[`OSS_WRITE_BIT];
				sel_q  <= sel_now;
				word_q <= word_d;
			end
		end
	end

	// status bits: hardware completion clears; a new start in the same cycle wins
	always @(posedge clock) begin
		if (reset) begin
			cmd_q <= `OSS_CMD_RESET;
		end else if (clk_en) begin
			if (cal_done && cmd_q[`OSS_BIT_RUN_CAL]) begin
				cmd_q[`OSS_BIT_RUN_CAL]  <= 1'b0;
				cmd_q[`OSS_BIT_CAL_FAIL] <= ~cal_ok;
			end
			if (save_done)
				cmd_q[`OSS_BIT_SAVE_CAL] <= 1'b0;
			if (wr_run) begin
				cmd_q[`OSS_BIT_RUN_CAL]  <= 1'b1;
				cmd_q[`OSS_BIT_CAL_FAIL] <= 1'b0;
			end
			if (wr_save)
				cmd_q[`OSS_BIT_SAVE_CAL] <= 1'b1;
			cmd_q[15:8] <= 8'h00;
		end
	end

	assign run_cal_bit  = cmd_q[`OSS_BIT_RUN_CAL];
	assign save_cal_bit = cmd_q[`OSS_BIT_SAVE_CAL];

	////////////////////////////////////////////////////////////////////
	// ready, analog level and heater
	always @(posedge clock) begin
		if (reset) begin
			ready_out        <= 1'b0;
			analog_level_out <= `OSS_LEVEL_ZERO;
			heater_en        <= 1'b0;
		end else if (clk_en) begin
			heater_en <= stby_n_s;
			if (!stby_n_s || !sensor_ready) begin
				ready_out        <= 1'b0;
				analog_level_out <= `OSS_LEVEL_ZERO;
			end else begin
				ready_out        <= 1'b1;
				analog_level_out <= oxygen_level;
			end
		end
	end
endmodule // oss_slave

//--- oss_slave_sva.sv
// oss_slave_sva.sv: port checks for oss_slave
// assumes sensor-side inputs stay steady while clk_en is low
`timescale 1ns/1ps
module oss_slave_sva (
	input wire        clock,
	input wire        reset,
	input wire        cs_n,
	input wire        miso_oe_n,
	input wire        standby_n,
	input wire        sensor_ready,
	input wire [15:0] oxygen_level,
	input wire        cal_done,
	input wire        cal_ok,
	input wire        save_done,
	input wire        ready_out,
	input wire [15:0] analog_level_out,
	input wire        heater_en,
	input wire        run_cal_bit,
	input wire        save_cal_bit
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (reset);
	a_ready_src: assert property (!sensor_ready |=> !ready_out)
		else $error("ready without sensor");
	a_ready_level: assert property (ready_out |-> analog_level_out == $past(oxygen_level))
		else $error("level not following");
	a_unready_zero: assert property (!ready_out |-> analog_level_out == 16'h0000)
		else $error("level not zero");
	a_standby_off: assert property (!standby_n [*4] |=> !ready_out && !heater_en)
		else $error("standby ignored");
	a_heater_on: assert property (standby_n [*4] |=> heater_en)
		else $error("heater off");
	a_oe_idle: assert property (cs_n [*4] |=> miso_oe_n)
		else $error("driving while idle");
	a_oe_drive: assert property (!cs_n [*4] |=> !miso_oe_n)
		else $error("not driving");
	a_run_clear: assert property ($fell(run_cal_bit) && !$past(reset) |-> $past(cal_done))
		else $error("run bit cleared early");
	a_save_clear: assert property ($fell(save_cal_bit) && !$past(reset) |-> $past(save_done))
		else $error("save bit cleared early");
	a_save_set: assert property ($rose(save_cal_bit) |-> !cs_n)
		else $error("save bit set outside frame");
	c_standby: cover property (!standby_n && !ready_out);
	c_cal_fail: cover property (cal_done && !cal_ok && run_cal_bit);
	c_save: cover property (save_done && save_cal_bit);
endmodule // oss_slave_sva

bind oss_slave oss_slave_sva oss_slave_sva_inst (.clock, .reset, .cs_n, .miso_oe_n,
	.standby_n, .sensor_ready, .oxygen_level, .cal_done, .cal_ok, .save_done,
	.ready_out, .analog_level_out, .heater_en, .run_cal_bit, .save_cal_bit);

//--- oss_host.sv
// oss_host.sv: host master model, mode 0, msb first
// assumes caller gives whole three-byte frames
`timescale 1ns/1ps
module oss_host #(
	parameter HALF = 6
) (
	input  wire  clock,
	output logic sclk,
	output logic cs_n,
	output logic mosi,
	input  wire  miso
);
	initial begin
		sclk = 0;
		cs_n = 1;
		mosi = 0;
	end
	// six clocks per half period: a 600 ns link period stays under 1.82 MHz
	task automatic frame(input logic [23:0] tx, output logic [23:0] rx);
		@(negedge clock);
		cs_n = 0;
		repeat (20) @(negedge clock);
		for (int i = 23; i >= 0; i--) begin
			mosi = tx[i];
			repeat (HALF) @(negedge clock);
			sclk = 1;
			rx[i] = miso;
			repeat (HALF) @(negedge clock);
			sclk = 0;
		end
		repeat (10) @(negedge clock);
		cs_n = 1;
		mosi = ~mosi;
		repeat (20) @(negedge clock);
	endtask
endmodule // oss_host

//--- oss_slave_bench.sv
// oss_slave_bench.sv: self-checking bench for oss_slave
// assumes oss_host drives the link; sensor inputs come from here
`timescale 1ns/1ps
module oss_slave_bench;
	logic clock = 0, reset = 1, clk_en = 1, standby_n = 1, sensor_ready = 0, v;
	logic cal_done = 0, cal_ok = 0, save_done = 0;
	logic [7:0] fault_code = 0;
	logic [15:0] oxygen_value = 0, air_ratio_value = 0, oxygen_level = 0;
	wire sclk, cs_n, mosi, miso, miso_oe_n, run_cal_bit, save_cal_bit, ready_out, heater_en;
	wire miso_line = miso_oe_n ? 1'b1 : miso; // released line rests at its pull-up
	wire [15:0] analog_level_out;
	logic [23:0] rx, exp_q[$];
	logic [31:0] rs = 8055;
	logic [7:0] codes[9] = '{8'h00, 8'h01, 8'h14, 8'h15, 8'h31, 8'h32, 8'h41, 8'h51, 8'h52};
	int fail_count = 0, tests_run = 0;
	event got;
	always #25 clock = ~clock;
	oss_host oss_host_inst (.clock, .sclk, .cs_n, .mosi, .miso(miso_line));
	oss_slave oss_slave_inst (.clock, .reset, .clk_en, .sclk, .cs_n, .mosi, .miso,
		.miso_oe_n, .standby_n, .fault_code, .sensor_ready, .oxygen_value,
		.air_ratio_value, .oxygen_level, .cal_done, .cal_ok, .save_done, .ready_out,
		.analog_level_out, .heater_en, .run_cal_bit, .save_cal_bit);
	function logic [15:0] rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs[15:0];
	endfunction
	task automatic check(string what, logic [23:0] seen, logic [23:0] want);
		tests_run++;
		if (seen !== want) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, want, seen);
		end
	endtask
	task give_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	always @(got) check("frame", rx, exp_q.pop_front());
	task rd(logic [6:0] sel, logic [15:0] w);
		exp_q.push_back({fault_code, w[7:0], w[15:8]});
		oss_host_inst.frame({1'b0, sel, rnd()}, rx);
		-> got;
	endtask
	task wr(logic [6:0] sel, logic [7:0] d);
		oss_host_inst.frame({1'b1, sel, d, 8'h5a}, rx);
	endtask
	task automatic pulse(ref logic s, input logic ok);
		@(negedge clock);
		cal_ok = ok;
		s = 1;
		@(negedge clock);
		s = 0;
	endtask
	initial begin
		#2000000;
		fail_count++;
		give_verdict;
	end
	initial begin
		repeat (5) @(negedge clock);
		reset = 0;
		oxygen_level = rnd();
		fault_code = 8'h41;
		repeat (10) @(negedge clock);
		check("warm", {7'h0, ready_out, analog_level_out}, 24'h0);
		check("idle oe", {23'h0, miso_oe_n}, 24'h1);
		rd(7'h01, 16'h8000);
		@(negedge clock);
		fault_code = 8'h00;
		sensor_ready = 1;
		repeat (5) @(negedge clock);
		check("ready", {7'h0, ready_out, analog_level_out}, {8'h1, oxygen_level});
		foreach (codes[i]) begin
			@(negedge clock);
			fault_code = codes[i];
			oxygen_value = rnd();
			air_ratio_value = rnd();
			v = codes[i] inside {8'h00, 8'h31, 8'h32};
			rd(7'h01, v ? oxygen_value : 16'h8000);
			rd(7'h02, v ? air_ratio_value : 16'h0000);
		end
		@(negedge clock);
		fault_code = 8'h00;
		wr(7'h00, 8'h01);
		rd(7'h00, 16'h0001);
		pulse(cal_done, 1'b0);
		rd(7'h00, 16'h0020);
		wr(7'h00, 8'h08);
		check("bits", {22'h0, run_cal_bit, save_cal_bit}, 24'h1);
		pulse(save_done, 1'b0);
		wr(7'h00, 8'h01);
		@(negedge clock);
		clk_en = 0;
		pulse(cal_done, 1'b1);
		check("frozen", {23'h0, run_cal_bit}, 24'h1);
		clk_en = 1;
		pulse(cal_done, 1'b1);
		rd(7'h00, 16'h0000);
		wr(7'h01, 8'h55);
		rd(7'h01, oxygen_value);
		wr(7'h00, 8'h09);
		@(negedge clock);
		reset = 1;
		repeat (2) @(negedge clock);
		check("reset", {4'h0, ready_out, heater_en, run_cal_bit, save_cal_bit,
			analog_level_out}, 24'h0);
		reset = 0;
		repeat (3) @(negedge clock);
		rd(7'h00, 16'h0000);
		@(negedge clock);
		standby_n = 0;
		repeat (5) @(negedge clock);
		check("standby", {6'h0, ready_out, heater_en, analog_level_out}, 24'h0);
		rd(7'h01, 16'h8000);
		@(negedge clock);
		give_verdict;
	end
endmodule // oss_slave_bench
